/* core/status_event_reporting.sv */
// Status byte, condition and event registers with service request
`timescale 1ns/100ps
`default_nettype none

module status_event_reporting (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic                  trig_ext_in,
  input  wire status_pkg::instr_cond_t cond_in,
  input  wire logic [7:0]            std_cond,
  input  wire logic                  err_queue_nonempty,
  input  wire logic                  msg_available,
  input  wire status_pkg::reg_req_t  req,
  output var  logic [15:0]           rd_data,
  output var  logic                  rd_valid,
  output var  logic [7:0]            status_byte,
  output var  logic                  srq_out,
  output var  logic                  srq_oe
);

  status_pkg::top_state_t st_reg;
  status_pkg::top_state_t st_next;

  logic [15:0] oper_evt;
  logic [15:0] ques_evt;
  logic [7:0]  std_evt;
  logic        oper_sum;
  logic        ques_sum;
  logic        std_sum;
  logic        clr_oper;
  logic        clr_ques;
  logic        clr_std;
  logic [15:0] oper_raw;
  logic [15:0] ques_raw;
  logic        prot_any;

  // Event reads clear the matching group
  assign clr_oper = req.rd && (req.sel == status_pkg::SEL_OPER_EVT);
  assign clr_ques = req.rd && (req.sel == status_pkg::SEL_QUES_EVT);
  assign clr_std  = req.rd && (req.sel == status_pkg::SEL_STD_EVT);

  status_group #(
    .W (status_pkg::OPER_W)
  ) u_oper (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .cond       (st_reg.oper_cond),
    .enable     (st_reg.oper_en),
    .clear      (clr_oper),
    .event_bits (oper_evt),
    .summary    (oper_sum)
  );

  status_group #(
    .W (status_pkg::QUES_W)
  ) u_ques (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .cond       (st_reg.ques_cond),
    .enable     (st_reg.ques_en),
    .clear      (clr_ques),
    .event_bits (ques_evt),
    .summary    (ques_sum)
  );

  status_group #(
    .W (status_pkg::STD_W)
  ) u_std (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .cond       (std_cond),
    .enable     (st_reg.std_en),
    .clear      (clr_std),
    .event_bits (std_evt),
    .summary    (std_sum)
  );

  always_comb begin
    st_next = st_reg;
    oper_raw = 16'h0000;
    ques_raw = 16'h0000;

    // Trigger pin is asynchronous to ref_clk
    st_next.trig_s1 = trig_ext_in;
    st_next.trig_s2 = st_reg.trig_s1;

    // waiting, or held while pin low
    oper_raw[status_pkg::OPER_TRIG_WAIT_BIT] =
      cond_in.trig_enabled | (cond_in.trig_src_ext & ~st_reg.trig_s2);
    oper_raw[status_pkg::OPER_TRANS_ARM_BIT] = cond_in.trans_armed;
    oper_raw[status_pkg::OPER_CV_BIT] = cond_in.cv_mode;
    oper_raw[status_pkg::OPER_CC_BIT] = cond_in.cc_mode;
    oper_raw[status_pkg::OPER_TRANS_DONE_BIT] = cond_in.trans_done;
    oper_raw[status_pkg::OPER_LIST_DONE_BIT]  = cond_in.list_done;
    oper_raw[status_pkg::OPER_SAMPLE_BIT]   = cond_in.sample_done;
    oper_raw[status_pkg::OPER_LIST_RUN_BIT] = cond_in.list_running;
    st_next.oper_cond = oper_raw & status_pkg::OPER_EVT_MASK;

    ques_raw[status_pkg::QUES_VMODE_BIT] = cond_in.cc_mode;
    ques_raw[status_pkg::QUES_CMODE_BIT] = cond_in.cv_mode;
    ques_raw[status_pkg::QUES_THERMAL_BIT] = cond_in.thermal_err;
    ques_raw[status_pkg::QUES_SLAVE_BIT]   = cond_in.slave_fault;
    prot_any = cond_in.volt_prot_err | cond_in.curr_prot_err;
    ques_raw[status_pkg::QUES_VPROT_BIT] =
      cond_in.volt_prot_err | (cond_in.ext_ref_en & prot_any);
    ques_raw[status_pkg::QUES_CPROT_BIT] =
      cond_in.curr_prot_err | (cond_in.ext_ref_en & prot_any);
    ques_raw[status_pkg::QUES_SINK_BIT] = cond_in.sinking;
    st_next.ques_cond = ques_raw & status_pkg::QUES_MASK;

    // low unless queue or questionable event
    st_next.stb[status_pkg::STB_ERR_BIT] = err_queue_nonempty | ques_sum;
    st_next.stb[status_pkg::STB_MSG_BIT]  = msg_available;
    st_next.stb[status_pkg::STB_STD_BIT]  = std_sum;
    st_next.stb[status_pkg::STB_OPER_BIT] = oper_sum;
    st_next.stb[2:0] = 3'h0;

    // Enable writes land before the RQS summary so srq_en and bit 6 agree
    if (req.wr) begin
      case (req.sel)
        status_pkg::SEL_OPER_EN: st_next.oper_en = req.wdata;
        status_pkg::SEL_QUES_EN: st_next.ques_en = req.wdata;
        status_pkg::SEL_STD_EN:  st_next.std_en  = req.wdata[7:0];
        status_pkg::SEL_SRQ_EN:  st_next.srq_en  = req.wdata[7:0];
        default:                 st_next.srq_en  = st_reg.srq_en;
      endcase
    end

    st_next.stb[status_pkg::STB_RQS_BIT] =
      |(st_next.stb & st_next.srq_en & status_pkg::RQS_EXCL_MASK);
    st_next.srq_oe  = st_next.stb[status_pkg::STB_RQS_BIT];
    st_next.srq_out = 1'b0;

    // Event reads return the value before the clear
    st_next.rd_valid = req.rd;
    if (req.rd) begin
      case (req.sel)
        status_pkg::SEL_OPER_COND:
          st_next.rd_data = st_reg.oper_cond & status_pkg::OPER_READ_MASK;
        status_pkg::SEL_OPER_EVT:  st_next.rd_data = oper_evt;
        status_pkg::SEL_OPER_EN:   st_next.rd_data = st_reg.oper_en;
        status_pkg::SEL_QUES_COND: st_next.rd_data = st_reg.ques_cond;
        status_pkg::SEL_QUES_EVT:  st_next.rd_data = ques_evt;
        status_pkg::SEL_QUES_EN:   st_next.rd_data = st_reg.ques_en;
        status_pkg::SEL_STD_EVT:   st_next.rd_data = {8'h00, std_evt};
        status_pkg::SEL_STD_EN:    st_next.rd_data = {8'h00, st_reg.std_en};
        status_pkg::SEL_STB:       st_next.rd_data = {8'h00, st_reg.stb};
        status_pkg::SEL_SRQ_EN:    st_next.rd_data = {8'h00, st_reg.srq_en};
        default:                   st_next.rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_reg         <= '0;
      st_reg.oper_en <= status_pkg::ENABLE_RST;
      st_reg.ques_en <= status_pkg::ENABLE_RST;
      st_reg.std_en  <= status_pkg::ENABLE_RST[7:0];
      st_reg.srq_en  <= status_pkg::ENABLE_RST[7:0];
      st_reg.stb     <= status_pkg::STB_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data     = st_reg.rd_data;
  assign rd_valid    = st_reg.rd_valid;
  assign status_byte = st_reg.stb;
  assign srq_out     = st_reg.srq_out;
  assign srq_oe      = st_reg.srq_oe;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  clean_decode_a: assert property (
    (!err_queue_nonempty && !ques_sum) |=> !status_byte[3])
    else $error("status bit 3 set without cause");

  msg_avail_a: assert property (
    msg_available |=> status_byte[4])
    else $error("message available bit missing");

  ques_to_stb_a: assert property (
    ($rose(cond_in.cc_mode) && st_reg.ques_en[0] && !req.wr && !req.rd)
      |-> ##[1:4] status_byte[3])
    else $error("questionable event did not reach status bit 3");

  rqs_summary_a: assert property (
    status_byte[6] == |(status_byte & st_reg.srq_en & 8'hbf))
    else $error("service summary bit 6 wrong");

  srq_line_a: assert property (
    (srq_oe == status_byte[6]) && !srq_out)
    else $error("service request line disagrees with bit 6");

  err_queue_a: assert property (
    err_queue_nonempty |=> status_byte[3])
    else $error("error queue not shown in bit 3");

  oper_unused_a: assert property (
    (req.rd && req.sel == status_pkg::SEL_OPER_COND)
      |=> rd_valid && ((rd_data & 16'ha09f) == 16'h0000))
    else $error("unused operation bit read nonzero");

  trig_wait_a: assert property (
    cond_in.trig_enabled |=> st_reg.oper_cond[5])
    else $error("waiting for trigger bit not set");

  done_hidden_a: assert property (
    (req.rd && req.sel == status_pkg::SEL_OPER_COND)
      |=> ((rd_data & 16'h1200) == 16'h0000))
    else $error("completion bit visible in condition read");

  mode_bits_a: assert property (
    (cond_in.cv_mode && !cond_in.cc_mode)
      |=> st_reg.oper_cond[8] && !st_reg.oper_cond[10] && st_reg.ques_cond[1])
    else $error("regulation mode bits wrong");

  prot_both_a: assert property (
    (cond_in.ext_ref_en && (cond_in.volt_prot_err || cond_in.curr_prot_err))
      |=> st_reg.ques_cond[12] && st_reg.ques_cond[13])
    else $error("external reference protection not doubled");

  ques_unused_a: assert property (
    ##1 ((st_reg.ques_cond & 16'h8fb4) == 16'h0000))
    else $error("unused questionable bit set");

endmodule // status_event_reporting

`default_nettype wire

/* inc/status_pkg.sv */
// Shared constants and types for the status reporting block
package status_pkg;

  localparam int OPER_W = 16;
  localparam int QUES_W = 16;
  localparam int STD_W  = 8;
  localparam int SRQ_W  = 8;

  localparam int OPER_TRIG_WAIT_BIT  = 5;
  localparam int OPER_TRANS_ARM_BIT  = 6;
  localparam int OPER_CV_BIT         = 8;
  localparam int OPER_TRANS_DONE_BIT = 9;
  localparam int OPER_CC_BIT         = 10;
  localparam int OPER_SAMPLE_BIT     = 11;
  localparam int OPER_LIST_DONE_BIT  = 12;
  localparam int OPER_LIST_RUN_BIT   = 14;

  localparam int QUES_VMODE_BIT   = 0;
  localparam int QUES_CMODE_BIT   = 1;
  localparam int QUES_THERMAL_BIT = 3;
  localparam int QUES_SLAVE_BIT   = 6;
  localparam int QUES_VPROT_BIT   = 12;
  localparam int QUES_CPROT_BIT   = 13;
  localparam int QUES_SINK_BIT    = 14;

  localparam int STB_ERR_BIT  = 3;
  localparam int STB_MSG_BIT  = 4;
  localparam int STB_STD_BIT  = 5;
  localparam int STB_RQS_BIT  = 6;
  localparam int STB_OPER_BIT = 7;

  // Condition bits visible on a condition read
  localparam logic [15:0] OPER_READ_MASK = 16'h4d60;
  // Operation bits that may ever latch an event
  localparam logic [15:0] OPER_EVT_MASK  = 16'h5f60;
  localparam logic [15:0] QUES_MASK      = 16'h704b;
  localparam logic [7:0]  RQS_EXCL_MASK  = 8'hbf;

  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [7:0]  STB_RST    = 8'h00;

  typedef enum logic [3:0] {
    SEL_OPER_COND,
    SEL_OPER_EVT,
    SEL_OPER_EN,
    SEL_QUES_COND,
    SEL_QUES_EVT,
    SEL_QUES_EN,
    SEL_STD_EVT,
    SEL_STD_EN,
    SEL_STB,
    SEL_SRQ_EN
  } reg_sel_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    reg_sel_t    sel;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic trig_enabled;
    logic trig_src_ext;
    logic trans_armed;
    logic cv_mode;
    logic cc_mode;
    logic trans_done;
    logic sample_done;
    logic list_done;
    logic list_running;
    logic thermal_err;
    logic slave_fault;
    logic volt_prot_err;
    logic curr_prot_err;
    logic ext_ref_en;
    logic sinking;
  } instr_cond_t;

  typedef struct packed {
    logic        trig_s1;
    logic        trig_s2;
    logic [15:0] oper_cond;
    logic [15:0] ques_cond;
    logic [15:0] oper_en;
    logic [15:0] ques_en;
    logic [7:0]  std_en;
    logic [7:0]  srq_en;
    logic [7:0]  stb;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        srq_oe;
    logic        srq_out;
  } top_state_t;

endpackage

/* core/status_group.sv */
// One condition group: edge latch, clear on read, enable summary
`timescale 1ns/100ps
`default_nettype none

module status_group #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] cond,
  input  wire logic [W-1:0] enable,
  input  wire logic         clear,
  output var  logic [W-1:0] event_bits,
  output var  logic         summary
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] evt;
    logic         sum;
  } grp_state_t;

  grp_state_t st_reg;
  grp_state_t st_next;
  logic [W-1:0] rise;

  always_comb begin
    st_next = st_reg;
    rise = cond & ~st_reg.prev;
    st_next.prev = cond;
    st_next.evt = (clear ? '0 : st_reg.evt) | rise;
    st_next.sum = |(st_next.evt & enable);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign event_bits = st_reg.evt;
  assign summary    = st_reg.sum;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  edge_kept_a: assert property (
    (|rise) |=> ((event_bits & $past(rise)) == $past(rise)))
    else $error("rising condition lost from event bits");

  read_clear_a: assert property (
    (clear && !(|rise)) |=> (event_bits == '0))
    else $error("event bits not cleared by read");

  summary_gate_a: assert property (
    ##1 (summary == |(event_bits & $past(enable))))
    else $error("summary does not follow enabled events");

endmodule // status_group

`default_nettype wire

/* bench/host_ctrl.sv */
// Host controller model: register requests and pulled-up service line
`timescale 1ns/100ps
`default_nettype none

module host_ctrl (
  input  wire logic                 ref_clk,
  input  wire logic [15:0]          rd_data,
  input  wire logic                 rd_valid,
  input  wire logic                 srq_out,
  input  wire logic                 srq_oe,
  output var  status_pkg::reg_req_t req,
  output wire logic                 srq_line_n
);
  // Pull-up: a released line reads high, never the last driven value
  assign srq_line_n = srq_oe ? srq_out : 1'b1;

  initial req = '0;

  // One idle cycle after each request keeps strobes single per step
  task automatic wr_reg(input status_pkg::reg_sel_t s, input logic [15:0] d);
    req.wr    = 1'b1;
    req.sel   = s;
    req.wdata = d;
    @(posedge ref_clk);
    #1;
    req = '0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd_reg(input status_pkg::reg_sel_t s, output logic [15:0] d, output logic v);
    req.rd  = 1'b1;
    req.sel = s;
    @(posedge ref_clk);
    #1;
    v   = rd_valid;
    d   = rd_data;
    req = '0;
    @(posedge ref_clk);
    #1;
  endtask
endmodule // host_ctrl

`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the status reporting block
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic                    ref_clk;
  logic                    rstn;
  logic                    trig_ext_in;
  logic                    err_q;
  logic                    msg_av;
  logic                    rd_valid;
  logic                    srq_out;
  logic                    srq_oe;
  wire logic               srq_line_n;
  logic [7:0]              std_cond;
  logic [7:0]              status_byte;
  logic [15:0]             rd_data;
  status_pkg::instr_cond_t cond_in;
  status_pkg::reg_req_t    req;
  int                      fails;
  int                      compares;
  logic [31:0]             seed;
  logic [15:0]             opr, qpr, oev, qev, oen, qen, q;
  logic [7:0]              spr, sev, sen, ren;
  logic                    v;

  status_event_reporting u_dut (
    .ref_clk            (ref_clk),
    .rstn               (rstn),
    .trig_ext_in        (trig_ext_in),
    .cond_in            (cond_in),
    .std_cond           (std_cond),
    .err_queue_nonempty (err_q),
    .msg_available      (msg_av),
    .req                (req),
    .rd_data            (rd_data),
    .rd_valid           (rd_valid),
    .status_byte        (status_byte),
    .srq_out            (srq_out),
    .srq_oe             (srq_oe)
  );

  host_ctrl u_host (
    .ref_clk    (ref_clk),
    .rd_data    (rd_data),
    .rd_valid   (rd_valid),
    .srq_out    (srq_out),
    .srq_oe     (srq_oe),
    .req        (req),
    .srq_line_n (srq_line_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 16; i++) s = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    return s;
  endfunction

  // Full operation view; bits 9 and 12 exist only as event sources
  function automatic logic [15:0] oper_fn(input status_pkg::instr_cond_t c, input logic pin);
    logic [15:0] r;
    r = '0;
    r[5]  = c.trig_enabled | (c.trig_src_ext & ~pin);
    r[6]  = c.trans_armed;
    r[8]  = c.cv_mode;
    r[9]  = c.trans_done;
    r[10] = c.cc_mode;
    r[11] = c.sample_done;
    r[12] = c.list_done;
    r[14] = c.list_running;
    return r;
  endfunction

  function automatic logic [15:0] ques_fn(input status_pkg::instr_cond_t c);
    logic [15:0] r;
    r = '0;
    r[0]  = c.cc_mode;
    r[1]  = c.cv_mode;
    r[3]  = c.thermal_err;
    r[6]  = c.slave_fault;
    r[12] = c.volt_prot_err | (c.ext_ref_en & c.curr_prot_err);
    r[13] = c.curr_prot_err | (c.ext_ref_en & c.volt_prot_err);
    r[14] = c.sinking;
    return r;
  endfunction

  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input status_pkg::reg_sel_t s, input logic [15:0] e, input string n);
    logic [15:0] d;
    logic        ok;
    u_host.rd_reg(s, d, ok);
    chk("rd_valid", {15'h0, ok}, 16'h1);
    chk(n, d, e);
  endtask

  task automatic upd();
    logic [15:0] n;
    n = oper_fn(cond_in, trig_ext_in);
    oev |= n & ~opr;
    opr = n;
    n = ques_fn(cond_in);
    qev |= n & ~qpr;
    qpr = n;
    sev |= std_cond & ~spr;
    spr = std_cond;
  endtask

  task automatic chk_stb();
    logic [7:0] e;
    e = '0;
    e[3] = err_q | (|(qev & qen));
    e[4] = msg_av;
    e[5] = |(sev & sen);
    e[7] = |(oev & oen);
    e[6] = |(e & ren & 8'hbf);
    chk("status_byte", {8'h0, status_byte}, {8'h0, e});
    chk("srq_oe", {15'h0, srq_oe}, {15'h0, e[6]});
    chk("srq_line_n", {15'h0, srq_line_n}, {15'h0, !e[6]});
    chk("srq_out", {15'h0, srq_out}, 16'h0);
  endtask

  task automatic results();
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    results();
  end

  initial begin
    {rstn, err_q, msg_av, std_cond, cond_in} = '0;
    trig_ext_in = 1'b1;
    seed = 32'h983daef0;
    {opr, qpr, oev, qev, oen, qen, spr, sev, sen, ren} = '0;
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'b1;
    chk_stb();
    rd(status_pkg::SEL_OPER_EN, 16'h0, "oper_en");
    rd(status_pkg::SEL_QUES_EN, 16'h0, "ques_en");
    rd(status_pkg::SEL_SRQ_EN, 16'h0, "srq_en");
    rd(status_pkg::reg_sel_t'(4'hf), 16'h0, "unmapped");
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      trig_ext_in = seed[0];
      step(6);
      upd();
      seed = lfsr(seed);
      cond_in = status_pkg::instr_cond_t'(seed[14:0]);
      std_cond = seed[22:15];
      err_q = seed[23];
      msg_av = seed[24];
      // Quiet bus edge so a mode change meets the old enables alone
      step(1);
      seed = lfsr(seed);
      oen = seed[15:0];
      qen = seed[31:16];
      u_host.wr_reg(status_pkg::SEL_OPER_EN, oen);
      u_host.wr_reg(status_pkg::SEL_QUES_EN, qen);
      seed = lfsr(seed);
      sen = seed[7:0];
      ren = seed[23:16];
      u_host.wr_reg(status_pkg::SEL_STD_EN, seed[15:0]);
      u_host.wr_reg(status_pkg::SEL_SRQ_EN, seed[31:16]);
      // Read-only place: write must leave the condition view alone
      u_host.wr_reg(status_pkg::SEL_OPER_COND, seed[15:0]);
      step(2);
      upd();
      chk_stb();
      rd(status_pkg::SEL_OPER_COND, opr & 16'hedff, "oper_cond");
      rd(status_pkg::SEL_QUES_COND, qpr, "ques_cond");
      rd(status_pkg::SEL_STD_EN, {8'h0, sen}, "std_en");
      rd(status_pkg::SEL_SRQ_EN, {8'h0, ren}, "srq_en");
      rd(status_pkg::SEL_OPER_EVT, oev, "oper_evt");
      oev = '0;
      rd(status_pkg::SEL_QUES_EVT, qev, "ques_evt");
      qev = '0;
      rd(status_pkg::SEL_STD_EVT, {8'h0, sev}, "std_evt");
      sev = '0;
      step(4);
      chk_stb();
    end
    // Rising edge lands on the very edge that takes the clearing read
    cond_in = '0;
    trig_ext_in = 1'b1;
    step(6);
    upd();
    u_host.rd_reg(status_pkg::SEL_OPER_EVT, q, v);
    cond_in.trans_done = 1'b1;
    step(1);
    u_host.rd_reg(status_pkg::SEL_OPER_EVT, q, v);
    u_host.rd_reg(status_pkg::SEL_OPER_EVT, q, v);
    chk("oper_evt_kept", {15'h0, q[9]}, 16'h1);
    results();
  end
endmodule // tb

`default_nettype wire
